// [verilog/sfp_pkg.sv]
// constants, types and shared helpers of the channel passivation policy
// assumes both link ends and the testbench import it before use
`default_nettype none

package sfp_pkg;

   // channel count and process value width
   localparam int NUM_CH = 8;
   localparam int PV_W = 16;

   // substitute process value of a passivated channel
   localparam logic [PV_W-1:0] SUBST_VALUE = 16'h0000;

   // safety address limits, 1 .. 65534
   localparam logic [15:0] ADDR_MIN = 16'h0001;
   localparam logic [15:0] ADDR_MAX = 16'hFFFE;

   // behaviour after a channel fault
   localparam logic REACT_MODULE = 1'b0;
   localparam logic REACT_CHANNEL = 1'b1;
   localparam logic REACT_DEFAULT = REACT_CHANNEL;

   // reintegration after a channel fault
   localparam logic [1:0] REINT_ADJUST = 2'h0;
   localparam logic [1:0] REINT_ALL_AUTO = 2'h1;
   localparam logic [1:0] REINT_ALL_MANUAL = 2'h2;
   localparam logic [1:0] REINT_DEFAULT = REINT_ALL_MANUAL;

   // per channel defaults: manual ack, 4..20 mA range, wire break on
   localparam logic [NUM_CH-1:0] ACK_AUTO_DEFAULT = 8'h00;
   localparam logic [NUM_CH-1:0] RANGE_LZ_DEFAULT = 8'hFF;
   localparam logic [NUM_CH-1:0] WB_EN_DEFAULT = 8'hFF;

   // parameter error codes reported by the device
   localparam logic [1:0] PERR_NONE = 2'h0;
   localparam logic [1:0] PERR_ADDR = 2'h1;
   localparam logic [1:0] PERR_COMBO = 2'h2;
   localparam logic [1:0] PERR_RUN = 2'h3;

   // channel reintegration states
   typedef enum logic [1:0] {
      SFP_CH_OK = 2'b00,
      SFP_CH_FAULT = 2'b01,
      SFP_CH_WAIT_ACK = 2'b10
   } sfp_ch_state_t;

   // device configuration states
   typedef enum logic {
      SFP_DEV_UNCONF = 1'b0,
      SFP_DEV_CONF = 1'b1
   } sfp_dev_state_t;

   // controller sequencing states
   typedef enum logic [1:0] {
      SFP_CT_IDLE = 2'b00,
      SFP_CT_SEND = 2'b01,
      SFP_CT_RUN = 2'b10
   } sfp_ct_state_t;

   // a safety address lies within 1 .. 65534
   function automatic logic addr_ok(input logic [15:0] addr);
      addr_ok = (addr >= ADDR_MIN) && (addr <= ADDR_MAX);
   endfunction

endpackage

`default_nettype wire

// [verilog/sfp_link_if.sv]
// link between the safety controller and the current input module
// assumes both ends share clk_in; the testbench instantiates and joins them
`timescale 1ns/1ps
`default_nettype none

interface sfp_link_if;
   import sfp_pkg::*;

   // parameter delivery
   logic prm_valid;
   logic prm_accept;
   logic prm_reject;
   logic fault_react;
   logic [1:0] reint_mode;
   logic [NUM_CH-1:0] ack_auto;
   logic [NUM_CH-1:0] range_lz;
   logic [NUM_CH-1:0] wb_en;
   logic [15:0] src_addr;
   logic [15:0] dst_addr;
   // operation
   logic run;
   logic ack_req;
   logic [NUM_CH-1:0][PV_W-1:0] pv;
   logic [NUM_CH-1:0] passivated;
   logic [NUM_CH-1:0] ack_needed;

   modport device (
      input prm_valid, fault_react, reint_mode, ack_auto, range_lz, wb_en,
      input src_addr, dst_addr, run, ack_req,
      output prm_accept, prm_reject, pv, passivated, ack_needed
   );

   modport ctrl (
      output prm_valid, fault_react, reint_mode, ack_auto, range_lz, wb_en,
      output src_addr, dst_addr, run, ack_req,
      input prm_accept, prm_reject, pv, passivated, ack_needed
   );
endinterface

`default_nettype wire

// [verilog/sfp_chan_ctl.sv]
// one channel's passivation and reintegration state
// assumes fault and mode inputs are already resolved by the device end
`timescale 1ns/1ps
`default_nettype none

module sfp_chan_ctl
   import sfp_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic enable_in,
   input wire logic fault_in,
   input wire logic auto_in,
   input wire logic ack_in,
   output logic passive_out,
   output logic ack_needed_out
);
   sfp_ch_state_t state;
   sfp_ch_state_t next_state;

   // fault passivates; reintegration by ack or automatically
   always_comb begin
      next_state = state;
      unique case (state)
         SFP_CH_OK: begin
            if (fault_in) begin
               next_state = SFP_CH_FAULT;
            end
         end
         SFP_CH_FAULT: begin
            if (!fault_in) begin
               next_state = auto_in ? SFP_CH_OK : SFP_CH_WAIT_ACK; // [RULE_04]
            end
         end
         SFP_CH_WAIT_ACK: begin
            if (fault_in) begin
               next_state = SFP_CH_FAULT; // fault wins over ack
            end else if (ack_in || auto_in) begin
               next_state = SFP_CH_OK;
            end
         end
         default: begin
            next_state = SFP_CH_FAULT;
         end
      endcase
   end

   // state register, forced to SFP_CH_OK while not configured
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= SFP_CH_OK;
      end else if (ce_in) begin
         state <= enable_in ? next_state : SFP_CH_OK;
      end
   end

   assign passive_out = (state != SFP_CH_OK);
   assign ack_needed_out = (state == SFP_CH_WAIT_ACK);
endmodule

`default_nettype wire

// [verilog/sfp_device.sv]
// fault reaction and parameter policy of the eight channel current input
// assumes acquisition logic supplies faults and measured values on clk_in
//
// Operation
// RULE_01 - fault passivates module or only faulty channels
// RULE_02 - per channel reintegration only with channel passivation
// RULE_03 - module passivation uses one common reintegration type
// RULE_04 - adjustable mode: channel ack setting decides reintegration
// RULE_05 - controller sends address pair before operation
// RULE_06 - controller gives unique destination address 1..65534
// RULE_07 - destination address may be set manually
// RULE_08 - source address comes from controller base
// RULE_09 - wire break diagnostic only on 4..20 mA
// RULE_10 - user enables diagnostics to suit wiring
// RULE_11 - parameters accepted at startup, rejected while running
// RULE_12 - passivated or discrepant channel delivers value zero
`timescale 1ns/1ps
`default_nettype none

module sfp_device
   import sfp_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   sfp_link_if.device link,
   input wire logic [NUM_CH-1:0] chan_fault_in,
   input wire logic [NUM_CH-1:0] wire_break_in,
   input wire logic [NUM_CH-1:0] discrepancy_in,
   input wire logic [NUM_CH-1:0][PV_W-1:0] meas_value_in,
   output logic configured_out,
   output logic [1:0] param_err_out,
   output logic [NUM_CH-1:0] wb_active_out,
   output logic module_passive_out
);
   sfp_dev_state_t state;
   logic cfg_react;
   logic [1:0] cfg_reint;
   logic [NUM_CH-1:0] cfg_ack_auto;
   logic [NUM_CH-1:0] cfg_wb;
   logic [15:0] cfg_src;
   logic [15:0] cfg_dst;
   logic set_ok;
   logic [1:0] set_err;
   logic take;
   logic refuse;
   logic [NUM_CH-1:0] fault_now;
   logic any_fault;
   logic [NUM_CH-1:0] ch_fault;
   logic [NUM_CH-1:0] ch_auto;
   logic [NUM_CH-1:0] ch_passive;
   logic [NUM_CH-1:0] ch_ack_needed;
   logic [NUM_CH-1:0] pass_reg;
   logic [NUM_CH-1:0][PV_W-1:0] pv_reg;
   logic [NUM_CH-1:0] ack_reg;

   // check an offered parameter set
   always_comb begin
      set_err = PERR_NONE;
      if (!addr_ok(link.src_addr) || !addr_ok(link.dst_addr)) begin
         set_err = PERR_ADDR; // [RULE_05]
      end else if ((link.fault_react == REACT_MODULE) &&
                   (link.reint_mode == REINT_ADJUST)) begin
         set_err = PERR_COMBO; // [RULE_02]
      end else if (link.reint_mode == 2'h3) begin
         set_err = PERR_COMBO; // unused code
      end
      set_ok = (set_err == PERR_NONE);
   end

   // accept only before the controller runs, refuse otherwise
   assign take = link.prm_valid && !link.run && set_ok; // [RULE_11]
   assign refuse = link.prm_valid && (link.run || !set_ok); // [RULE_11]
   assign link.prm_accept = take && ce_in;
   assign link.prm_reject = refuse && ce_in;

   // configuration state
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= SFP_DEV_UNCONF;
      end else if (ce_in && take) begin
         state <= SFP_DEV_CONF;
      end
   end

   // stored parameter set, loaded only on acceptance
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cfg_react <= REACT_DEFAULT; // [RULE_01]
         cfg_reint <= REINT_DEFAULT;
         cfg_ack_auto <= ACK_AUTO_DEFAULT;
         cfg_wb <= WB_EN_DEFAULT & RANGE_LZ_DEFAULT;
         cfg_src <= ADDR_MIN;
         cfg_dst <= ADDR_MIN;
      end else if (ce_in && take) begin
         cfg_react <= link.fault_react;
         cfg_reint <= link.reint_mode;
         cfg_ack_auto <= link.ack_auto;
         cfg_wb <= link.wb_en & link.range_lz; // [RULE_09]
         cfg_src <= link.src_addr;
         cfg_dst <= link.dst_addr;
      end
   end

   // last parameter outcome
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         param_err_out <= PERR_NONE;
      end else if (ce_in && link.prm_valid) begin
         if (link.run) begin
            param_err_out <= PERR_RUN;
         end else begin
            param_err_out <= set_err;
         end
      end
   end

   // channel fault: own fault, discrepancy, or enabled wire break
   assign fault_now = chan_fault_in | discrepancy_in | (wire_break_in & cfg_wb); // [RULE_09]
   assign any_fault = |fault_now;

   // resolve fault source and reintegration type per channel
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (cfg_react == REACT_MODULE) begin
            ch_fault[i] = any_fault; // [RULE_01]
            ch_auto[i] = (cfg_reint == REINT_ALL_AUTO); // [RULE_03]
         end else begin
            ch_fault[i] = fault_now[i]; // [RULE_01]
            if (cfg_reint == REINT_ADJUST) begin
               ch_auto[i] = cfg_ack_auto[i]; // [RULE_02] [RULE_04]
            end else begin
               ch_auto[i] = (cfg_reint == REINT_ALL_AUTO);
            end
         end
      end
   end

   // one state machine per channel
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      sfp_chan_ctl u_ch (
         .clk_in(clk_in),
         .reset_in(reset_in),
         .ce_in(ce_in),
         .enable_in(state == SFP_DEV_CONF),
         .fault_in(ch_fault[g]),
         .auto_in(ch_auto[g]),
         .ack_in(link.ack_req && link.run),
         .passive_out(ch_passive[g]),
         .ack_needed_out(ch_ack_needed[g])
      );
   end

   // passivation status; unconfigured means all passive
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pass_reg <= '1;
         ack_reg <= '0;
      end else if (ce_in) begin
         if (state == SFP_DEV_CONF) begin
            pass_reg <= ch_passive;
            ack_reg <= ch_ack_needed;
         end else begin
            pass_reg <= '1;
            ack_reg <= '0;
         end
      end
   end

   // process values with substitute zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pv_reg <= '0;
      end else if (ce_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if ((state != SFP_DEV_CONF) || ch_passive[i] || discrepancy_in[i]) begin
               pv_reg[i] <= SUBST_VALUE; // [RULE_12]
            end else begin
               pv_reg[i] <= meas_value_in[i];
            end
         end
      end
   end

   // link and user side outputs
   assign link.pv = pv_reg;
   assign link.passivated = pass_reg;
   assign link.ack_needed = ack_reg;
   assign configured_out = (state == SFP_DEV_CONF);
   assign wb_active_out = cfg_wb;
   assign module_passive_out = &pass_reg;
endmodule

`default_nettype wire

// [verilog/sfp_ctrl.sv]
// safety controller end: sends the parameter set, runs, acknowledges
// assumes the user side supplies the configuration and a start pulse
`timescale 1ns/1ps
`default_nettype none

module sfp_ctrl
   import sfp_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   sfp_link_if.ctrl link,
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic ack_in,
   input wire logic fault_react_in,
   input wire logic [1:0] reint_mode_in,
   input wire logic [NUM_CH-1:0] ack_auto_in,
   input wire logic [NUM_CH-1:0] range_lz_in,
   input wire logic [NUM_CH-1:0] wb_en_in,
   input wire logic [15:0] src_base_in,
   input wire logic [15:0] auto_dst_in,
   input wire logic manual_dst_en_in,
   input wire logic [15:0] manual_dst_in,
   output logic running_out,
   output logic param_rejected_out,
   output logic addr_err_out,
   output logic [NUM_CH-1:0][PV_W-1:0] pv_out,
   output logic [NUM_CH-1:0] passivated_out
);
   sfp_ct_state_t state;
   logic [15:0] dst_sel;
   logic addr_good;

   // destination: automatic or manual override; source from base
   assign dst_sel = manual_dst_en_in ? manual_dst_in : auto_dst_in; // [RULE_07] [RULE_06]
   assign addr_good = addr_ok(dst_sel) && addr_ok(src_base_in); // [RULE_06] [RULE_08]

   // sequence: send parameters, then run
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= SFP_CT_IDLE;
      end else if (ce_in) begin
         unique case (state)
            SFP_CT_IDLE: begin
               if (start_in && addr_good) begin
                  state <= SFP_CT_SEND; // [RULE_05]
               end
            end
            SFP_CT_SEND: begin
               if (link.prm_accept) begin
                  state <= SFP_CT_RUN;
               end else if (link.prm_reject) begin
                  state <= SFP_CT_IDLE;
               end
            end
            SFP_CT_RUN: begin
               if (stop_in) begin
                  state <= SFP_CT_IDLE;
               end
            end
            default: begin
               state <= SFP_CT_IDLE;
            end
         endcase
      end
   end

   // parameter set, captured at start
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         link.fault_react <= REACT_DEFAULT;
         link.reint_mode <= REINT_DEFAULT;
         link.ack_auto <= ACK_AUTO_DEFAULT;
         link.range_lz <= RANGE_LZ_DEFAULT;
         link.wb_en <= WB_EN_DEFAULT; // [RULE_10]
         link.src_addr <= ADDR_MIN;
         link.dst_addr <= ADDR_MIN;
      end else if (ce_in && (state == SFP_CT_IDLE) && start_in && addr_good) begin
         link.fault_react <= fault_react_in;
         link.reint_mode <= reint_mode_in;
         link.ack_auto <= ack_auto_in;
         link.range_lz <= range_lz_in;
         link.wb_en <= wb_en_in;
         link.src_addr <= src_base_in; // [RULE_08]
         link.dst_addr <= dst_sel; // [RULE_07]
      end
   end

   // status flags
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         param_rejected_out <= 1'b0;
         addr_err_out <= 1'b0;
      end else if (ce_in) begin
         if ((state == SFP_CT_SEND) && link.prm_reject) begin
            param_rejected_out <= 1'b1;
         end else if (start_in) begin
            param_rejected_out <= 1'b0;
         end
         if ((state == SFP_CT_IDLE) && start_in) begin
            addr_err_out <= !addr_good;
         end
      end
   end

   // mirrored process image
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pv_out <= '0;
         passivated_out <= '1;
      end else if (ce_in) begin
         pv_out <= link.pv;
         passivated_out <= link.passivated;
      end
   end

   assign link.prm_valid = (state == SFP_CT_SEND);
   assign link.run = (state == SFP_CT_RUN);
   assign link.ack_req = ack_in && (state == SFP_CT_RUN);
   assign running_out = (state == SFP_CT_RUN);
endmodule

`default_nettype wire

// [test/sfp_link_checker.sv]
// concurrent checks on the link between controller and input module
// assumes the bench instantiates it beside the link and ties ce_in high
`timescale 1ns/1ps
`default_nettype none

module sfp_link_checker
   import sfp_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic prm_valid,
   input wire logic prm_accept,
   input wire logic prm_reject,
   input wire logic fault_react,
   input wire logic [1:0] reint_mode,
   input wire logic [NUM_CH-1:0] ack_auto,
   input wire logic [15:0] src_addr,
   input wire logic [15:0] dst_addr,
   input wire logic run,
   input wire logic ack_req,
   input wire logic [NUM_CH-1:0][PV_W-1:0] pv,
   input wire logic [NUM_CH-1:0] passivated,
   input wire logic [NUM_CH-1:0] ack_needed
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // every passivated channel carries the substitute value
   logic subst_ok;
   always_comb begin
      subst_ok = 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
         if (passivated[i] && pv[i] != SUBST_VALUE) subst_ok = 1'b0;
      end
   end

   // set taken, then running with the offer withdrawn
   sequence set_taken;
      prm_valid && prm_accept;
   endsequence
   sequence run_entered;
      run && !prm_valid;
   endsequence
   sequence acked;
      run && ack_req && ack_needed != 8'h00;
   endsequence

   accept_idle_a: assert property (prm_accept |-> !run && !prm_reject)
      else $error("set accepted while running");
   set_runs_a: assert property (set_taken |=> run_entered)
      else $error("run not entered after accept");
   combo_refused_a: assert property (prm_valid && fault_react == REACT_MODULE
      && reint_mode == REINT_ADJUST |-> prm_reject) else $error("combo not refused");
   code_refused_a: assert property (prm_valid && reint_mode == 2'h3 |-> prm_reject)
      else $error("illegal reintegration code taken");
   addr_range_a: assert property (prm_accept |-> src_addr != 16'h0000
      && src_addr != 16'hFFFF && dst_addr != 16'h0000 && dst_addr != 16'hFFFF)
      else $error("address out of range taken");
   subst_zero_a: assert property (subst_ok)
      else $error("passivated channel not zero");
   module_whole_a: assert property (run && fault_react == REACT_MODULE
      |-> passivated == 8'h00 || passivated == 8'hFF) else $error("partial passivation");
   auto_noack_a: assert property (run && reint_mode == REINT_ALL_AUTO |-> ack_needed == 8'h00)
      else $error("ack wanted in automatic mode");
   adjust_auto_a: assert property (run && reint_mode == REINT_ADJUST
      |-> (ack_needed & ack_auto) == 8'h00) else $error("ack wanted on automatic channel");
   ack_release_a: assert property (acked |-> ##[1:3] ack_needed == 8'h00)
      else $error("ack did not release channel");
endmodule

`default_nettype wire

// [test/sfp_bench.sv]
// self-checking bench joining controller and input module over the link
// assumes the package, link and both ends are compiled before it
`timescale 1ns/1ps
`default_nettype none

module sfp_bench;
   import sfp_pkg::*;

`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

   logic clk_in, reset_in, start_in, stop_in, ack_in, fault_react_in, manual_dst_en_in;
   logic [1:0] reint_mode_in;
   logic [7:0] ack_auto_in, range_lz_in, wb_en_in, fault, wbreak, discr;
   logic [15:0] src_base_in, auto_dst_in, manual_dst_in;
   logic [NUM_CH-1:0][PV_W-1:0] meas, pv_out;
   logic [7:0] passivated_out, wb_active_out;
   logic [1:0] param_err_out;
   logic running_out, param_rejected_out, addr_err_out, configured_out, module_passive_out;
   int n_errors = 0;
   int compares = 0;
   // selectors of the one-cycle controller strobes
   localparam int P_START = 0;
   localparam int P_STOP = 1;
   localparam int P_ACK = 2;

   sfp_link_if link();
   sfp_device i_sfp_device(.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1), .link(link),
      .chan_fault_in(fault), .wire_break_in(wbreak), .discrepancy_in(discr),
      .meas_value_in(meas), .configured_out(configured_out), .param_err_out(param_err_out),
      .wb_active_out(wb_active_out), .module_passive_out(module_passive_out));
   sfp_ctrl i_sfp_ctrl(.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1), .link(link),
      .start_in(start_in), .stop_in(stop_in), .ack_in(ack_in), .fault_react_in(fault_react_in),
      .reint_mode_in(reint_mode_in), .ack_auto_in(ack_auto_in), .range_lz_in(range_lz_in),
      .wb_en_in(wb_en_in), .src_base_in(src_base_in), .auto_dst_in(auto_dst_in),
      .manual_dst_en_in(manual_dst_en_in), .manual_dst_in(manual_dst_in),
      .running_out(running_out), .param_rejected_out(param_rejected_out),
      .addr_err_out(addr_err_out), .pv_out(pv_out), .passivated_out(passivated_out));
   sfp_link_checker i_sfp_link_checker(.clk_in(clk_in), .reset_in(reset_in),
      .prm_valid(link.prm_valid), .prm_accept(link.prm_accept), .prm_reject(link.prm_reject),
      .fault_react(link.fault_react), .reint_mode(link.reint_mode), .ack_auto(link.ack_auto),
      .src_addr(link.src_addr), .dst_addr(link.dst_addr), .run(link.run),
      .ack_req(link.ack_req), .pv(link.pv), .passivated(link.passivated),
      .ack_needed(link.ack_needed));

   // 250 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // expected process values for a passivation pattern
   function automatic logic [NUM_CH-1:0][PV_W-1:0] exp_pv(input logic [7:0] pass);
      for (int i = 0; i < NUM_CH; i++) exp_pv[i] = pass[i] ? SUBST_VALUE : meas[i];
   endfunction

   task automatic finish_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one-cycle pulse on start, stop or ack, driven directly on the module signals
   task automatic pulse(input int which);
      @(posedge clk_in);
      start_in <= (which == P_START);
      stop_in <= (which == P_STOP);
      ack_in <= (which == P_ACK);
      @(posedge clk_in);
      {start_in, stop_in, ack_in} <= 3'h0;
   endtask

   // start with a set; dst 0 picks the automatic destination address
   task automatic configure(input logic react, input logic [1:0] reint, input logic [7:0] am,
                            input logic [15:0] dst);
      @(posedge clk_in);
      fault_react_in <= react;
      reint_mode_in <= reint;
      ack_auto_in <= am;
      manual_dst_en_in <= (dst != 16'h0000);
      manual_dst_in <= dst;
      pulse(P_START);
      repeat (4) @(posedge clk_in);
      #1;
   endtask

   // bounded wait for a passivation and ack pattern, then the values
   task automatic wait_flags(input logic [7:0] pass, input logic [7:0] need);
      int n;
      n = 0;
      while ((passivated_out !== pass || link.ack_needed !== need) && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      if (passivated_out !== pass || link.ack_needed !== need) begin
         n_errors++;
         finish_test();
      end
      `CHECK(pv_out, exp_pv(pass))
   endtask

   // fault sources, applied on the rising edge
   task automatic set_faults(input logic [7:0] f, input logic [7:0] w, input logic [7:0] d);
      @(posedge clk_in);
      fault <= f;
      wbreak <= w;
      discr <= d;
   endtask

   // main sequence
   initial begin
      {start_in, stop_in, ack_in, fault_react_in, manual_dst_en_in} = 5'h00;
      {reint_mode_in, ack_auto_in, fault, wbreak, discr, manual_dst_in} = '0;
      range_lz_in = 8'h0F;
      wb_en_in = 8'hFF;
      src_base_in = 16'h0010;
      auto_dst_in = 16'h0042;
      for (int i = 0; i < NUM_CH; i++) meas[i] = 16'h1000 + 16'(i);
      reset_in = 1'b1;
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      `CHECK(link.passivated, 8'hFF)
      `CHECK(configured_out, 1'b0)
      configure(REACT_DEFAULT, REINT_DEFAULT, ACK_AUTO_DEFAULT, 16'h0000);
      `CHECK(configured_out, 1'b1)
      `CHECK(link.dst_addr, 16'h0042)
      `CHECK(link.src_addr, 16'h0010)
      `CHECK(wb_active_out, 8'h0F)
      `CHECK(param_err_out, PERR_NONE)
      // a new start while running must leave the taken set untouched
      configure(REACT_MODULE, REINT_ALL_AUTO, 8'hFF, 16'h0000);
      `CHECK({running_out, link.fault_react, link.reint_mode}, {1'b1, REACT_DEFAULT, REINT_DEFAULT})
      wait_flags(8'h00, 8'h00);
      set_faults(8'h04, 8'h81, 8'h00);
      wait_flags(8'h05, 8'h00);
      set_faults(8'h00, 8'h00, 8'h00);
      wait_flags(8'h05, 8'h05);
      pulse(P_ACK);
      wait_flags(8'h00, 8'h00);
      set_faults(8'h00, 8'h00, 8'h08);
      wait_flags(8'h08, 8'h00);
      set_faults(8'h00, 8'h00, 8'h00);
      pulse(P_ACK);
      wait_flags(8'h00, 8'h00);
      pulse(P_STOP);
      configure(REACT_MODULE, REINT_ADJUST, 8'h00, 16'h1234);
      `CHECK({param_rejected_out, param_err_out, running_out}, {1'b1, PERR_COMBO, 1'b0})
      configure(REACT_CHANNEL, 2'h3, 8'h00, 16'h1234);
      `CHECK({param_rejected_out, running_out}, 2'h2)
      configure(REACT_CHANNEL, REINT_ALL_MANUAL, 8'h00, 16'hFFFF);
      `CHECK({addr_err_out, running_out}, 2'h2)
      configure(REACT_MODULE, REINT_ALL_AUTO, 8'h00, 16'hFFFE);
      `CHECK(running_out, 1'b1)
      wait_flags(8'h00, 8'h00);
      set_faults(8'h20, 8'h00, 8'h00);
      wait_flags(8'hFF, 8'h00);
      `CHECK(module_passive_out, 1'b1)
      set_faults(8'h00, 8'h00, 8'h00);
      wait_flags(8'h00, 8'h00);
      pulse(P_STOP);
      configure(REACT_CHANNEL, REINT_ADJUST, 8'h01, 16'h0001);
      `CHECK(link.dst_addr, 16'h0001)
      wait_flags(8'h00, 8'h00);
      set_faults(8'h03, 8'h00, 8'h00);
      wait_flags(8'h03, 8'h00);
      set_faults(8'h00, 8'h00, 8'h00);
      wait_flags(8'h02, 8'h02);
      pulse(P_ACK);
      wait_flags(8'h00, 8'h00);
      pulse(P_STOP);
      finish_test();
   end
endmodule

`default_nettype wire
